//--- hdl/rsdp_pkg.sv
// Constants and types shared by the raw serial data port
package rsdp_pkg;

   // Register offsets on the plain register port
   localparam logic [7:0] OFS_PIN2_CFG = 8'h00;
   localparam logic [7:0] OFS_PIN1_CFG = 8'h01;
   localparam logic [7:0] OFS_PIN0_CFG = 8'h02;
   localparam logic [7:0] OFS_PKT_CTRL_B = 8'h08;
   localparam logic [7:0] OFS_MODEM_CFG_C = 8'h12;
   localparam logic [7:0] OFS_RATE_LO = 8'h20;
   localparam logic [7:0] OFS_RATE_HI = 8'h21;
   localparam logic [7:0] OFS_STATUS = 8'h22;
   localparam logic [7:0] OFS_STROBE_RX = 8'h34;
   localparam logic [7:0] OFS_STROBE_TX = 8'h35;
   localparam logic [7:0] OFS_STROBE_IDLE = 8'h36;

   // Field positions
   localparam int FMT_MSB = 5;
   localparam int FMT_LSB = 4;
   localparam int MANCH_BIT = 3;
   localparam int SEL_MSB = 5;

   // Field encodings
   localparam logic [1:0] FMT_SYNC = 2'h1;
   localparam logic [1:0] FMT_ASYNC = 2'h3;
   localparam logic [5:0] SEL_SERIAL_DATA = 6'h0d;
   localparam logic [5:0] SEL_SERIAL_CLK = 6'h0b;
   localparam logic [5:0] SEL_HIGH_Z = 6'h2e;

   // Values after reset
   localparam logic [7:0] RST_PIN_CFG = 8'h2e;
   localparam logic [7:0] RST_PKT_CTRL = 8'h05;
   localparam logic [7:0] RST_MODEM_CFG = 8'h00;
   localparam logic [15:0] RST_RATE = 16'h0013;

   // Counts
   localparam logic [2:0] LAST_PHASE = 3'h7;
   localparam logic [2:0] HALF_PHASE = 3'h4;
   localparam int TX_LATENCY_BITS = 8;
   localparam int RX_LATENCY_BITS = 9;

   typedef enum logic [1:0] {RSDP_IDLE, RSDP_RX, RSDP_TX} rsdp_radio_type;

   // Register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } rsdp_regbus_type;

   // Drive of the three general pins
   typedef struct packed {
      logic [2:0] out;
      logic [2:0] oe;
   } rsdp_pin_drv_type;

endpackage

//--- hdl/rsdp_delay_line.sv
// Bit delay line holding the serial latency stages
`timescale 1ns/1ps
`default_nettype none
module rsdp_delay_line #(
   parameter int DEPTH = 8
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic en,
   input wire logic din,
   output logic dout
);
   typedef struct packed {
      logic [DEPTH-1:0] line;
      logic q;
   } rsdp_dl_type;

   rsdp_dl_type s_reg;
   rsdp_dl_type s_next;

   // Shift one stage per enable, output from a register
   always_comb begin
      s_next = s_reg;
      if (en) begin
         s_next.line = {s_reg.line[DEPTH-2:0], din};
         s_next.q = s_reg.line[DEPTH-1];
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign dout = s_reg.q;

   property p_dl_shift;
      @(posedge clk) disable iff (!rst_n) en |=> dout == $past(s_reg.line[DEPTH-1]);
   endproperty
   a_dl_shift: assert property (p_dl_shift) else $error("Delay line output did not shift");
endmodule
`default_nettype wire

//--- hdl/rsdp_top.sv
// Raw serial data port: asynchronous and synchronous serial modes
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module rsdp_top
   import rsdp_pkg::*;
(
   input wire logic SYS_CLK,
   input wire logic RESETN,
   input wire rsdp_regbus_type REG_BUS,
   output logic [7:0] REG_RDATA,
   input wire logic [2:0] GP_IN,
   output var rsdp_pin_drv_type GP_DRV,
   input wire logic DEMOD_LEVEL,
   output logic MOD_TX_BIT,
   output logic PKT_HANDLER_EN,
   output logic MANCHESTER_EN,
   output logic TX_ACTIVE,
   output logic RX_ACTIVE
);
   typedef struct packed {
      logic [7:0] pin2_cfg;
      logic [7:0] pin1_cfg;
      logic [7:0] pin0_cfg;
      logic [7:0] pkt_ctrl;
      logic [7:0] modem_cfg;
      logic [15:0] rate;
      rsdp_radio_type radio;
      logic [15:0] div;
      logic [2:0] phase;
      logic bclk;
      logic tx_meta;
      logic tx_pin;
      logic tx_mod;
      logic rx_out;
      logic [7:0] rdata;
      rsdp_pin_drv_type drv;
      logic pkt_en;
      logic manch_en;
   } rsdp_top_state_type;

   rsdp_top_state_type s_reg;
   rsdp_top_state_type s_next;

   logic tick;
   logic bit_en;
   logic async_mode;
   logic sync_mode;
   logic tx_q;
   logic rx_q;

   // Drive of one general pin: {oe, out}
   function automatic logic [1:0] pin_drive(
      input logic [5:0] sel,
      input logic serial,
      input logic data,
      input logic clk
   );
      logic [1:0] r;
      r = 2'b10;
      if (sel == SEL_HIGH_Z) begin
         r = 2'b00;
      end else if (serial && sel == SEL_SERIAL_DATA) begin
         r = {1'b1, data};
      end else if (serial && sel == SEL_SERIAL_CLK) begin
         r = {1'b1, clk};
      end
      return r;
   endfunction

   // Mode decode from the packet format field
   assign async_mode = s_reg.pkt_ctrl[FMT_MSB:FMT_LSB] == FMT_ASYNC;
   assign sync_mode = s_reg.pkt_ctrl[FMT_MSB:FMT_LSB] == FMT_SYNC;

   // Oversample tick and bit boundary
   assign tick = s_reg.div == 16'h0000;
   assign bit_en = tick && s_reg.phase == LAST_PHASE;

   // Transmit latency stages, advanced on bit clock rising edge
   rsdp_delay_line #(.DEPTH(TX_LATENCY_BITS)) u_tx_delay (
      .clk(SYS_CLK),
      .rst_n(RESETN),
      .en(bit_en),
      .din(s_reg.tx_pin),
      .dout(tx_q)
   );

   // Receive latency stages, same bit boundary
   rsdp_delay_line #(.DEPTH(RX_LATENCY_BITS)) u_rx_delay (
      .clk(SYS_CLK),
      .rst_n(RESETN),
      .en(bit_en),
      .din(DEMOD_LEVEL),
      .dout(rx_q)
   );

   // Next state of the whole port
   always_comb begin
      logic [1:0] d0;
      logic [1:0] d1;
      logic [1:0] d2;
      logic serial;
      logic tx_now;
      s_next = s_reg;
      d0 = 2'b00;
      d1 = 2'b00;
      d2 = 2'b00;
      serial = 1'b0;
      tx_now = 1'b0;

      // Divider to one-eighth-bit ticks
      s_next.div = tick ? s_reg.rate : s_reg.div - 16'h0001;
      if (tick) begin
         s_next.phase = s_reg.phase + 3'h1;
      end
      s_next.bclk = s_next.phase < HALF_PHASE;

      // Pin 0 input synchroniser
      s_next.tx_meta = GP_IN[0];
      s_next.tx_pin = s_reg.tx_meta;

      // Register writes and strobes
      if (REG_BUS.wr) begin
         unique case (REG_BUS.addr)
            OFS_PIN2_CFG: s_next.pin2_cfg = REG_BUS.wdata;
            OFS_PIN1_CFG: s_next.pin1_cfg = REG_BUS.wdata;
            OFS_PIN0_CFG: s_next.pin0_cfg = REG_BUS.wdata;
            OFS_PKT_CTRL_B: s_next.pkt_ctrl = REG_BUS.wdata;
            OFS_MODEM_CFG_C: s_next.modem_cfg = REG_BUS.wdata;
            OFS_RATE_LO: s_next.rate[7:0] = REG_BUS.wdata;
            OFS_RATE_HI: s_next.rate[15:8] = REG_BUS.wdata;
            OFS_STROBE_RX: s_next.radio = RSDP_RX;
            OFS_STROBE_TX: s_next.radio = RSDP_TX;
            OFS_STROBE_IDLE: s_next.radio = RSDP_IDLE;
            default: s_next.radio = s_reg.radio;
         endcase
      end

      // Modulator input: raw eighth-bit samples or delayed bit
      if (async_mode) begin
         if (tick) begin
            s_next.tx_mod = s_reg.tx_pin;
         end
      end else if (sync_mode) begin
         s_next.tx_mod = tx_q;
      end else begin
         s_next.tx_mod = 1'b0;
      end

      // Receive output: raw level, no decision, or delayed bit
      if (async_mode) begin
         if (tick) begin
            s_next.rx_out = DEMOD_LEVEL;
         end
      end else if (sync_mode) begin
         s_next.rx_out = rx_q;
      end else begin
         s_next.rx_out = 1'b0;
      end

      // Packet handling and Manchester gated off in raw mode
      s_next.pkt_en = !(s_next.pkt_ctrl[FMT_MSB:FMT_LSB] == FMT_ASYNC);
      s_next.manch_en = s_next.modem_cfg[MANCH_BIT] && s_next.pkt_en;

      // Pin routing: data out on selected pin, pin 0 input in transmit
      serial = async_mode || sync_mode;
      tx_now = serial && s_next.radio == RSDP_TX;
      d0 = pin_drive(s_next.pin0_cfg[SEL_MSB:0], serial, s_next.rx_out, s_next.bclk);
      d1 = pin_drive(s_next.pin1_cfg[SEL_MSB:0], serial, s_next.rx_out, s_next.bclk);
      d2 = pin_drive(s_next.pin2_cfg[SEL_MSB:0], serial, s_next.rx_out, s_next.bclk);
      if (tx_now) begin
         d0 = 2'b00;
      end
      s_next.drv.oe = {d2[1], d1[1], d0[1]};
      s_next.drv.out = {d2[0], d1[0], d0[0]};

      // Read data, valid in the cycle after the strobe
      if (REG_BUS.rd) begin
         unique case (REG_BUS.addr)
            OFS_PIN2_CFG: s_next.rdata = s_reg.pin2_cfg;
            OFS_PIN1_CFG: s_next.rdata = s_reg.pin1_cfg;
            OFS_PIN0_CFG: s_next.rdata = s_reg.pin0_cfg;
            OFS_PKT_CTRL_B: s_next.rdata = s_reg.pkt_ctrl;
            OFS_MODEM_CFG_C: s_next.rdata = s_reg.modem_cfg;
            OFS_RATE_LO: s_next.rdata = s_reg.rate[7:0];
            OFS_RATE_HI: s_next.rdata = s_reg.rate[15:8];
            OFS_STATUS: s_next.rdata = {2'h0, s_reg.rx_out, s_reg.bclk,
                                        async_mode, sync_mode, 2'(s_reg.radio)};
            default: s_next.rdata = 8'h00;
         endcase
      end
   end

   // State register
   always_ff @(posedge SYS_CLK or negedge RESETN) begin
      if (!RESETN) begin
         s_reg <= '0;
         s_reg.pin2_cfg <= RST_PIN_CFG;
         s_reg.pin1_cfg <= RST_PIN_CFG;
         s_reg.pin0_cfg <= RST_PIN_CFG;
         s_reg.pkt_ctrl <= RST_PKT_CTRL;
         s_reg.modem_cfg <= RST_MODEM_CFG;
         s_reg.rate <= RST_RATE;
         s_reg.radio <= RSDP_IDLE;
         s_reg.bclk <= 1'b1;
         s_reg.pkt_en <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   // Outputs, all from the state register
   assign REG_RDATA = s_reg.rdata;
   assign GP_DRV = s_reg.drv;
   assign MOD_TX_BIT = s_reg.tx_mod;
   assign PKT_HANDLER_EN = s_reg.pkt_en;
   assign MANCHESTER_EN = s_reg.manch_en;
   assign TX_ACTIVE = s_reg.radio == RSDP_TX;
   assign RX_ACTIVE = s_reg.radio == RSDP_RX;

   // Checks
   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!RESETN);

   property p_async_no_pkt;
      async_mode |-> !PKT_HANDLER_EN && !MANCHESTER_EN;
   endproperty
   a_async_no_pkt: assert property (p_async_no_pkt)
      else $error("Packet handling left on in async mode");

   property p_fmt_async;
      REG_BUS.wr && REG_BUS.addr == OFS_PKT_CTRL_B && REG_BUS.wdata[FMT_MSB:FMT_LSB] == 2'h3
         |=> async_mode ##1 !PKT_HANDLER_EN;
   endproperty
   a_fmt_async: assert property (p_fmt_async)
      else $error("Format 3 did not enter async mode");

   property p_fmt_sync;
      REG_BUS.wr && REG_BUS.addr == OFS_PKT_CTRL_B && REG_BUS.wdata[FMT_MSB:FMT_LSB] == 2'h1
         |=> sync_mode;
   endproperty
   a_fmt_sync: assert property (p_fmt_sync)
      else $error("Format 1 did not enter sync mode");

   property p_tx_pin0_input;
      REG_BUS.wr && REG_BUS.addr == OFS_STROBE_TX && (async_mode || sync_mode)
         && !(REG_BUS.rd) |=> !GP_DRV.oe[0] && TX_ACTIVE;
   endproperty
   a_tx_pin0_input: assert property (p_tx_pin0_input)
      else $error("Pin 0 still driven after transmit strobe");

   property p_sync_tx_input;
      sync_mode && TX_ACTIVE && $stable(s_reg.pkt_ctrl) |-> !GP_DRV.oe[0];
   endproperty
   a_sync_tx_input: assert property (p_sync_tx_input)
      else $error("Pin 0 driven during sync transmit");

   property p_async_sample;
      async_mode && tick |=> MOD_TX_BIT == $past(s_reg.tx_pin);
   endproperty
   a_async_sample: assert property (p_async_sample)
      else $error("Async transmit level not sampled on tick");

   property p_async_raw;
      async_mode && tick ##1 async_mode |-> s_reg.rx_out == $past(DEMOD_LEVEL);
   endproperty
   a_async_raw: assert property (p_async_raw)
      else $error("Raw level not passed to output");

   property p_rx_on_pin1;
      async_mode && s_reg.pin1_cfg[SEL_MSB:0] == SEL_SERIAL_DATA && $stable(s_reg.pin1_cfg)
         && $stable(s_reg.pkt_ctrl) |-> GP_DRV.oe[1] && GP_DRV.out[1] == s_reg.rx_out;
   endproperty
   a_rx_on_pin1: assert property (p_rx_on_pin1)
      else $error("Receive data missing on selected pin");

   // In sync mode, pin 0 carries receive data whenever it is selected for serial data and not transmitting
   property p_sync_rx_pin0;
      sync_mode && s_reg.pin0_cfg[SEL_MSB:0] == SEL_SERIAL_DATA && !TX_ACTIVE
         && $stable(s_reg.pin0_cfg) && $stable(s_reg.pkt_ctrl)
         |-> GP_DRV.oe[0] && GP_DRV.out[0] == s_reg.rx_out;
   endproperty
   a_sync_rx_pin0: assert property (p_sync_rx_pin0)
      else $error("Sync receive data missing on selected pin");

   property p_bclk_rise;
      bit_en |=> s_reg.bclk ##0 $rose(s_reg.bclk);
   endproperty
   a_bclk_rise: assert property (p_bclk_rise)
      else $error("Bit clock did not rise at bit boundary");

   property p_sync_tx_delay;
      sync_mode && $stable(s_reg.pkt_ctrl) |=> MOD_TX_BIT == $past(tx_q);
   endproperty
   a_sync_tx_delay: assert property (p_sync_tx_delay)
      else $error("Modulator not fed from transmit delay");

   property p_sync_rx_delay;
      sync_mode && $stable(s_reg.pkt_ctrl) |=> s_reg.rx_out == $past(rx_q);
   endproperty
   a_sync_rx_delay: assert property (p_sync_rx_delay)
      else $error("Receive output not fed from receive delay");

   c_async_tx: cover property (async_mode && TX_ACTIVE && tick);
   c_sync_rx: cover property (sync_mode && RX_ACTIVE && bit_en);
   c_sync_tx: cover property (sync_mode && TX_ACTIVE && bit_en ##2 $changed(MOD_TX_BIT));
endmodule
`default_nettype wire

//--- tb/rsdp_host_model.sv
// Host controller model streaming raw bits over the general pins
`timescale 1ns/1ps
`default_nettype none
module rsdp_host_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic async_mode,
   input wire logic bclk,
   input wire logic rxd,
   input wire logic [63:0] pattern,
   output logic txd,
   output logic [63:0] rx_seen,
   output logic [7:0] edges
);
   logic bclk_d;
   logic [5:0] cnt;
   // Own bit timer in async mode, bit clock falls in sync mode
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bclk_d <= 1'b0;
         cnt <= 6'h00;
         edges <= 8'h00;
         txd <= 1'b0;
         rx_seen <= '0;
      end else if (!run) begin
         txd <= ~txd; // Released line shows no stale level
         bclk_d <= bclk;
         cnt <= 6'h00;
         edges <= 8'h00;
      end else begin
         bclk_d <= bclk;
         cnt <= (cnt == 6'h27) ? 6'h00 : cnt + 6'h01; // Exact bit period
         if (async_mode ? (cnt == 6'h00) : (bclk_d && !bclk)) begin
            txd <= pattern[edges[5:0]]; // Raw bits, no framing
            rx_seen[edges[5:0]] <= rxd; // Sampled on the bit clock falling edge, or on the own timer in async mode
            edges <= edges + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

//--- tb/rsdp_top_bench.sv
// Self-checking bench for the raw serial data port
`timescale 1ns/1ps
`default_nettype none
module rsdp_top_bench
   import rsdp_pkg::*;
();
   logic sys_clk = 1'b0;
   logic resetn = 1'b0;
   rsdp_regbus_type bus = '0;
   logic [7:0] rdata;
   logic [2:0] gp_in;
   rsdp_pin_drv_type drv;
   logic demod = 1'b0;
   logic mod_bit, pkt_en, man_en, tx_act, rx_act;
   logic host_run = 1'b0;
   logic host_async = 1'b0;
   logic host_txd;
   logic flip = 1'b0;
   logic [63:0] tx_pat = 64'h9e3c_5a71_d20b_86f4;
   logic [63:0] rx_pat = 64'h4b1f_e3a6_0c97_58d2;
   logic [63:0] rx_seen;
   logic [7:0] edges;
   logic [7:0] got;
   int fails = 0;
   int checks = 0;
   int cycles = 0;

   // Clock and undriven pin levels
   always #2 sys_clk = ~sys_clk;
   always @(posedge sys_clk) flip <= ~flip;
   assign gp_in[0] = drv.oe[0] ? drv.out[0] : host_txd;
   assign gp_in[1] = drv.oe[1] ? drv.out[1] : flip;
   assign gp_in[2] = drv.oe[2] ? drv.out[2] : ~flip;

   rsdp_top dut (.SYS_CLK(sys_clk), .RESETN(resetn), .REG_BUS(bus), .REG_RDATA(rdata),
      .GP_IN(gp_in), .GP_DRV(drv), .DEMOD_LEVEL(demod), .MOD_TX_BIT(mod_bit),
      .PKT_HANDLER_EN(pkt_en), .MANCHESTER_EN(man_en), .TX_ACTIVE(tx_act),
      .RX_ACTIVE(rx_act));
   rsdp_host_model host (.clk(sys_clk), .rst_n(resetn), .run(host_run),
      .async_mode(host_async), .bclk(gp_in[2]), .rxd(gp_in[1]), .pattern(tx_pat),
      .txd(host_txd), .rx_seen(rx_seen), .edges(edges));

   task automatic stop_test();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   // Hang guard
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 40000) begin
         fails++;
         stop_test();
      end
   end

   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
      checks++;
      if (seen !== exp) begin
         fails++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge sys_clk);
      bus.wr <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge sys_clk);
      bus.rd <= 1'b0;
      #1 got = rdata;
   endtask

   task automatic next_edge();
      logic [7:0] e;
      int n;
      e = edges;
      n = 0;
      while (edges == e && n < 400) begin
         @(posedge sys_clk);
         n++;
      end
   endtask

   task automatic t_reset();
      check("pin drive", 8'h00, {5'h00, drv.oe});
      rd(OFS_PIN0_CFG);
      check("pin0 cfg", RST_PIN_CFG, got);
      rd(OFS_PKT_CTRL_B);
      check("pkt ctrl", RST_PKT_CTRL, got);
      rd(OFS_RATE_LO);
      check("rate lo", RST_RATE[7:0], got);
      rd(8'h7f);
      check("unmapped", 8'h00, got);
      $display("test reset done");
   endtask

   task automatic t_modes();
      wr(OFS_RATE_LO, 8'h04);
      wr(OFS_MODEM_CFG_C, 8'h08);
      wr(OFS_PKT_CTRL_B, 8'h04);
      repeat (40) @(posedge sys_clk);
      check("manchester packet", 8'h01, {7'h00, man_en});
      wr(OFS_PKT_CTRL_B, 8'h32);
      repeat (3) @(posedge sys_clk);
      check("packet handling", 8'h00, {7'h00, pkt_en});
      check("manchester async", 8'h00, {7'h00, man_en});
      rd(OFS_STATUS);
      check("status async", 8'h08, got & 8'h0f);
      wr(OFS_PKT_CTRL_B, 8'h12);
      rd(OFS_STATUS);
      check("status sync", 8'h04, got & 8'h0f);
      $display("test modes done");
   endtask

   task automatic t_async_tx();
      wr(OFS_PKT_CTRL_B, 8'h32);
      wr(OFS_PIN0_CFG, {2'b00, SEL_SERIAL_DATA});
      repeat (3) @(posedge sys_clk);
      check("pin0 drive idle", 8'h01, {7'h00, drv.oe[0]});
      wr(OFS_STROBE_TX, 8'h00);
      repeat (3) @(posedge sys_clk);
      check("pin0 drive tx", 8'h00, {7'h00, drv.oe[0]});
      check("tx active", 8'h01, {7'h00, tx_act});
      host_async <= 1'b1;
      host_run <= 1'b1;
      for (int k = 0; k < 20; k++) begin
         next_edge();
         repeat (20) @(posedge sys_clk);
         check("async tx bit", {7'h00, tx_pat[edges - 8'h01]}, {7'h00, mod_bit});
      end
      host_run <= 1'b0;
      wr(OFS_STROBE_IDLE, 8'h00);
      $display("test async tx done");
   endtask

   task automatic t_async_rx();
      for (int p = 0; p < 3; p++) begin
         for (int q = 0; q < 3; q++)
            wr(q[7:0], (q == 2 - p) ? {2'b00, SEL_SERIAL_DATA} : RST_PIN_CFG);
         wr(OFS_STROBE_RX, 8'h00);
         for (int k = 0; k < 6; k++) begin
            @(posedge sys_clk);
            demod <= rx_pat[6 * p + k];
            repeat (20) @(posedge sys_clk);
            check("async rx level", {7'h00, rx_pat[6 * p + k]}, {7'h00, drv.out[p]});
         end
         check("rx pin drive", 8'h01, {7'h00, drv.oe[p]});
         check("rx active", 8'h01, {7'h00, rx_act});
         wr(OFS_STROBE_IDLE, 8'h00);
      end
      $display("test async rx done");
   endtask

   task automatic t_sync();
      int t0;
      t0 = 0;
      wr(OFS_PKT_CTRL_B, 8'h12);
      wr(OFS_MODEM_CFG_C, 8'h00);
      wr(OFS_PIN2_CFG, {2'b00, SEL_SERIAL_CLK});
      wr(OFS_PIN1_CFG, {2'b00, SEL_SERIAL_DATA});
      wr(OFS_PIN0_CFG, {2'b00, SEL_SERIAL_DATA});
      wr(OFS_STROBE_TX, 8'h00);
      repeat (3) @(posedge sys_clk);
      check("sync pin0 drive tx", 8'h00, {7'h00, drv.oe[0]});
      host_async <= 1'b0;
      host_run <= 1'b1;
      for (int m = 0; m < 40; m++) begin
         next_edge();
         if (m > 0)
            check("bit clock period", 8'h28, 8'(cycles - t0));
         t0 = cycles;
         if (m >= 9)
            check("sync tx bit", {7'h00, tx_pat[m - 9]}, {7'h00, mod_bit});
      end
      host_run <= 1'b0;
      wr(OFS_STROBE_IDLE, 8'h00);
      wr(OFS_STROBE_RX, 8'h00);
      host_run <= 1'b1;
      for (int m = 0; m < 40; m++) begin
         next_edge();
         demod <= rx_pat[m];
         check("data pins agree", {7'h00, drv.out[1]}, {7'h00, drv.out[0]});
      end
      for (int m = 10; m < 40; m++)
         check("sync rx bit", {7'h00, rx_pat[m - 10]}, {7'h00, rx_seen[m]});
      host_run <= 1'b0;
      $display("test sync done");
   endtask

   // Main sequence
   initial begin
      repeat (12) @(posedge sys_clk);
      resetn <= 1'b1;
      t_reset();
      t_modes();
      t_async_tx();
      t_async_rx();
      t_sync();
      stop_test();
   end
endmodule
`default_nettype wire
